// ===== logic/slow_rate_defs.vh
`ifndef SLOW_RATE_DEFS_VH
`define SLOW_RATE_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_SLOW       8'h04
`define ADDR_RANGE      8'h08
`define ADDR_STATUS     8'h0C
`define ADDR_RAW        8'h10
`define ADDR_BUS_RES    8'h14
`define ADDR_SENSE_RES  8'h18
`define ADDR_POWER      8'h1C
`define ADDR_SNAP_CNT   8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_RATE_LO    0
`define CTRL_RATE_HI    1
`define CTRL_MODE_LO    2
`define CTRL_MODE_HI    3
`define CTRL_ALERT      4
`define CTRL_BUS_BIP    5
`define CTRL_SENSE_BIP  6
`define CTRL_RESET      32'h0000_0000

// sample mode codes
`define MODE_CONT       2'h0
`define MODE_SINGLE     2'h1
`define MODE_SLEEP      2'h2

// rate codes, rate 3 is 8 per second
`define RATE_1024       2'h0
`define RATE_8          2'h3

// ----------------------------------------------------------------
// slow register fields
// ----------------------------------------------------------------
`define SLOW_TYPE_NR    0
`define SLOW_DIS_RISE   1
`define SLOW_DIS_FALL   2
`define SLOW_LEVEL      3
`define SLOW_ROSE       4
`define SLOW_FELL       5
`define SLOW_RESET      3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_NS          10
`define WAKE_US         1000
`define SETTLE_US       1000

`endif

// ===== logic/slow_pin_rate_and_result_format.v
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "slow_rate_defs.vh"

module slow_pin_rate_and_result_format #(
    parameter CHANNELS   = 4,
    parameter WAKE_CYC   = (`WAKE_US * 1000) / `CLK_NS,
    parameter SETTLE_CYC = (`SETTLE_US * 1000) / `CLK_NS
) (
    // clock, reset, enable
    input  wire        I_SYS_CLK,
    input  wire        I_RST,
    input  wire        i_ce,
    // apb slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // rate-select / first alert pin
    input  wire        i_slow_pin,
    output reg         o_first_alert_output,
    output reg         o_first_alert_oe,
    input  wire        i_alert_level,
    // converter side
    input  wire        i_cycle_done,
    input  wire [1:0]  i_conv_chan,
    input  wire [16:0] i_bus_raw,
    input  wire [16:0] i_sense_raw,
    output reg         o_sample_start,
    output reg  [1:0]  o_active_rate,
    output reg         o_acc_clear,
    output reg         o_snapshot
);

// ----------------------------------------------------------------
// state and registers
// ----------------------------------------------------------------
localparam WAKE_W = 24;

reg  [31:0]   ctrl;
reg  [31:0]   ctrl_pending;
reg  [2:0]    slow_cfg;
reg           rose;
reg           fell;
reg  [7:0]    half_range;
reg           pin_meta;
reg           pin_sync;
reg           pin_prev;
reg           started;
reg           rate_slow;
reg  [WAKE_W-1:0] wake_cnt;
reg           wake_busy;
reg  [WAKE_W-1:0] settle_cnt;
reg  [15:0]   bus_live  [0:CHANNELS-1];
reg  [15:0]   sense_live[0:CHANNELS-1];
reg  [29:0]   power_live[0:CHANNELS-1];
reg  [15:0]   bus_snap  [0:CHANNELS-1];
reg  [15:0]   sense_snap[0:CHANNELS-1];
reg  [29:0]   power_snap[0:CHANNELS-1];
reg  [15:0]   snap_count;
reg  [1:0]    rd_chan;
integer       k;

wire          alert_mode = ctrl[`CTRL_ALERT];
wire [1:0]    prog_rate  = ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO];
wire [1:0]    samp_mode  = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
wire          bus_bip    = ctrl[`CTRL_BUS_BIP];
wire          sense_bip  = ctrl[`CTRL_SENSE_BIP];
wire          edge_rise  = pin_sync & ~pin_prev;
wire          edge_fall  = ~pin_sync & pin_prev;
wire          snap_fire  = ~alert_mode &
                           ((edge_rise & ~slow_cfg[`SLOW_DIS_RISE]) |
                            (edge_fall & ~slow_cfg[`SLOW_DIS_FALL]));
wire          acc_phase  = i_psel & i_penable;
wire          wr_en      = acc_phase & i_pwrite;
wire [1:0]    cc         = i_conv_chan;
// formatted bus result of the channel just converted; its 14 msbs, zero-extended, are the power result
wire [15:0]   bus_fmt    = fmt(i_bus_raw, bus_bip, half_range[cc]);

// ----------------------------------------------------------------
// formatting: 17-bit signed raw to 16-bit result
// ----------------------------------------------------------------
// unipolar and half range keep the low 16 bits (2^16 divisor); full
// bipolar drops the extra lsb (2^15 divisor). unipolar clamps negatives.
function [15:0] fmt;
    input [16:0] raw;
    input        bip;
    input        half;
    begin
        if (!bip) begin
            fmt = raw[16] ? 16'h0000 : raw[15:0];
        end else if (half) begin
            fmt = raw[15:0];
        end else begin
            fmt = raw[16:1];
        end
    end
endfunction

// ----------------------------------------------------------------
// pin synchroniser and edge detection
// ----------------------------------------------------------------
always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
        pin_meta <= 1'b0;
        pin_sync <= 1'b0;
        pin_prev <= 1'b0;
        started  <= 1'b0;
    end else if (i_ce) begin
        pin_meta <= i_slow_pin;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
        started  <= 1'b1;
    end
end

// ----------------------------------------------------------------
// rate selection
// ----------------------------------------------------------------
// the pin level is only looked at on a cycle boundary, so a channel
// conversion already running finishes at the old rate.
always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
        rate_slow     <= 1'b0;
        o_active_rate <= `RATE_1024;
    end else if (i_ce) begin
        if (!started) begin
            rate_slow <= 1'b0;
        end else if (alert_mode) begin
            rate_slow     <= 1'b0;
            o_active_rate <= prog_rate;
        end else if (i_cycle_done) begin
            rate_slow     <= pin_sync;
            o_active_rate <= pin_sync ? `RATE_8 : prog_rate;
        end
    end
end

// ----------------------------------------------------------------
// single-shot wake-up delay
// ----------------------------------------------------------------
always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
        wake_cnt       <= {WAKE_W{1'b0}};
        wake_busy      <= 1'b0;
        o_sample_start <= 1'b0;
    end else if (i_ce) begin
        o_sample_start <= 1'b0;
        if (samp_mode == `MODE_SLEEP) begin
            wake_busy <= 1'b0;
        end else if (edge_rise && !alert_mode && samp_mode == `MODE_SINGLE) begin
            wake_busy <= 1'b1;
            wake_cnt  <= WAKE_CYC[WAKE_W-1:0] - 1'b1;
        end else if (wake_busy) begin
            if (wake_cnt == {WAKE_W{1'b0}}) begin
                wake_busy      <= 1'b0;
                o_sample_start <= 1'b1;
            end else begin
                wake_cnt <= wake_cnt - 1'b1;
            end
        end
    end
end

// ----------------------------------------------------------------
// live results and snapshots
// ----------------------------------------------------------------
always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
        for (k = 0; k < CHANNELS; k = k + 1) begin
            bus_live[k]   <= 16'h0000;
            sense_live[k] <= 16'h0000;
            power_live[k] <= 30'h0000_0000;
            bus_snap[k]   <= 16'h0000;
            sense_snap[k] <= 16'h0000;
            power_snap[k] <= 30'h0000_0000;
        end
        o_acc_clear <= 1'b0;
        o_snapshot  <= 1'b0;
        snap_count  <= 16'h0000;
        settle_cnt  <= {WAKE_W{1'b0}};
        rose        <= 1'b0;
        fell        <= 1'b0;
    end else if (i_ce) begin
        if (i_cycle_done) begin
            bus_live[cc]   <= bus_fmt;
            sense_live[cc] <= fmt(i_sense_raw, sense_bip, half_range[cc + 4]);
            power_live[cc] <= {16'h0000, bus_fmt[15:2]};
        end
        o_snapshot  <= snap_fire;
        o_acc_clear <= snap_fire & ~slow_cfg[`SLOW_TYPE_NR];
        if (snap_fire) begin
            // control writes stay in ctrl_pending: snapshot does not apply them
            for (k = 0; k < CHANNELS; k = k + 1) begin
                bus_snap[k]   <= bus_live[k];
                sense_snap[k] <= sense_live[k];
                power_snap[k] <= power_live[k];
            end
            snap_count <= snap_count + 16'h0001;
            settle_cnt <= SETTLE_CYC[WAKE_W-1:0];
        end else if (settle_cnt != {WAKE_W{1'b0}}) begin
            settle_cnt <= settle_cnt - 1'b1;
        end
        // set wins over a software clear in the same cycle
        if (edge_rise && !alert_mode) begin
            rose <= 1'b1;
        end else if (wr_en && i_paddr == `ADDR_SLOW && i_pwdata[`SLOW_ROSE]) begin
            rose <= 1'b0;
        end
        if (edge_fall && !alert_mode) begin
            fell <= 1'b1;
        end else if (wr_en && i_paddr == `ADDR_SLOW && i_pwdata[`SLOW_FELL]) begin
            fell <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// apb slave, zero wait states
// ----------------------------------------------------------------
always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
        ctrl         <= `CTRL_RESET;
        ctrl_pending <= `CTRL_RESET;
        slow_cfg     <= `SLOW_RESET;
        half_range   <= 8'h00;
        rd_chan      <= 2'h0;
        o_prdata     <= 32'h0000_0000;
        o_pready     <= 1'b0;
        o_pslverr    <= 1'b0;
        o_first_alert_output <= 1'b0;
        o_first_alert_oe     <= 1'b0;
    end else if (i_ce) begin
        o_first_alert_oe     <= alert_mode;
        o_first_alert_output <= alert_mode & i_alert_level;
        // pending control is applied only at a cycle boundary
        if (i_cycle_done) begin
            ctrl <= ctrl_pending;
        end
        o_pready  <= i_psel & ~o_pready;
        o_pslverr <= 1'b0;
        if (i_psel && !o_pready) begin
            o_prdata <= 32'h0000_0000;
            case (i_paddr)
            `ADDR_CTRL: begin
                o_prdata <= ctrl_pending;
                if (i_pwrite) ctrl_pending <= i_pwdata;
            end
            `ADDR_SLOW: begin
                o_prdata <= {26'h0, fell, rose, pin_sync, slow_cfg};
                if (i_pwrite) slow_cfg <= i_pwdata[2:0];
            end
            `ADDR_RANGE: begin
                o_prdata <= {24'h0, half_range};
                if (i_pwrite) half_range <= i_pwdata[7:0];
            end
            `ADDR_STATUS: begin
                o_prdata <= {24'h0, settle_cnt != {WAKE_W{1'b0}}, wake_busy,
                             rate_slow, alert_mode, 2'h0, o_active_rate};
            end
            `ADDR_RAW: begin
                o_prdata <= {30'h0, rd_chan};
                if (i_pwrite) rd_chan <= i_pwdata[1:0];
            end
            `ADDR_BUS_RES:   o_prdata <= {16'h0, bus_snap[rd_chan]};
            `ADDR_SENSE_RES: o_prdata <= {16'h0, sense_snap[rd_chan]};
            `ADDR_POWER:     o_prdata <= {2'h0, power_snap[rd_chan]};
            `ADDR_SNAP_CNT:  o_prdata <= {16'h0, snap_count};
            default:         o_pslverr <= 1'b1;
            endcase
        end
    end
end

endmodule

// ===== test/slow_pin_properties.sv
`timescale 1ns/100ps
module slow_pin_properties (
    input wire       I_SYS_CLK,
    input wire       I_RST,
    input wire       i_ce,
    input wire       i_psel,
    input wire       i_penable,
    input wire       i_slow_pin,
    input wire       i_alert_level,
    input wire       i_cycle_done,
    input wire       o_pready,
    input wire       o_pslverr,
    input wire       o_first_alert_output,
    input wire       o_first_alert_oe,
    input wire       o_sample_start,
    input wire [1:0] o_active_rate,
    input wire       o_acc_clear,
    input wire       o_snapshot
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    // ----------------------------------------
    // steps of a transfer and of a pin edge
    // ----------------------------------------
    sequence s_setup;
        i_ce && i_psel && !i_penable && !o_pready;
    endsequence
    sequence s_pin_moved;
        $past(i_slow_pin, 3) != $past(i_slow_pin, 4);
    endsequence
    a_ready_time: assert property (s_setup |=> o_pready) else $error("late ready");
    a_ready_once: assert property (o_pready |=> !o_pready) else $error("ready too long");
    a_err_ready: assert property (o_pslverr |-> o_pready) else $error("lone error");
    a_alert_copy: assert property (o_first_alert_oe |->
        o_first_alert_output == $past(i_alert_level)) else $error("alert level lost");
    a_snap_edge: assert property (o_snapshot |-> s_pin_moved) else $error("stray snapshot");
    a_snap_once: assert property (o_snapshot |=> !o_snapshot) else $error("double snapshot");
    a_clear_snap: assert property (o_acc_clear |-> o_snapshot) else $error("clear alone");
    // rate may only move at a conversion cycle boundary
    a_rate_step: assert property ($changed(o_active_rate) |->
        $past(i_cycle_done) || $past(i_cycle_done, 2)) else $error("rate mid cycle");
    a_start_once: assert property (o_sample_start |=> !o_sample_start) else $error("long start");
endmodule

bind slow_pin_rate_and_result_format slow_pin_properties slow_pin_properties_i (.*);

// ===== test/conv_model.sv
`timescale 1ns/100ps
// converter stand-in: one channel per done pulse, data churns every cycle
module conv_model (
    input  wire        I_SYS_CLK,
    input  wire        I_RST,
    input  wire [31:0] i_rnd,
    output reg         o_done,
    output reg  [1:0]  o_chan,
    output reg  [16:0] o_bus,
    output reg  [16:0] o_sense
);
    reg [5:0] cnt;
    always @(posedge I_SYS_CLK) begin
        o_bus <= i_rnd[16:0];
        o_sense <= i_rnd[31:15];
        if (I_RST) begin
            cnt <= 6'h00;
            o_done <= 1'b0;
            o_chan <= 2'h0;
        end else begin
            cnt <= cnt + 6'h01;
            o_done <= (cnt == 6'h3F);
            if (o_done) o_chan <= o_chan + 2'h1;
        end
    end
endmodule

// ===== test/tb.sv
`timescale 1ns/100ps
`include "slow_rate_defs.vh"
module tb;
    reg          clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pin = 0, alvl = 0;
    reg  [7:0]   paddr = 8'h00;
    reg  [31:0]  pwdata = 32'h0, rnd = 32'h0000CD49;
    wire [31:0]  prdata;
    wire         prdy, perr, aout, aoe, done, sst, clr, snap;
    wire [1:0]   rate, chan;
    wire [16:0]  braw, sraw;
    logic [7:0]  nsnap = 0, nclr = 0, nsst = 0, s0, c0, n, m;
    logic [32:0] e;
    logic [32:0] exq[$];
    int          n_fail = 0, tests_run = 0;

    slow_pin_rate_and_result_format #(.WAKE_CYC(20), .SETTLE_CYC(20))
    slow_pin_rate_and_result_format_i (.I_SYS_CLK(clk), .I_RST(rst), .i_ce(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr), .i_slow_pin(pin),
        .o_first_alert_output(aout), .o_first_alert_oe(aoe), .i_alert_level(alvl),
        .i_cycle_done(done), .i_conv_chan(chan), .i_bus_raw(braw), .i_sense_raw(sraw),
        .o_sample_start(sst), .o_active_rate(rate), .o_acc_clear(clr), .o_snapshot(snap));
    conv_model conv_model_i (.I_SYS_CLK(clk), .I_RST(rst), .i_rnd(rnd), .o_done(done),
        .o_chan(chan), .o_bus(braw), .o_sense(sraw));

    // ----------------------------------------
    // stimulus helpers and result checking
    // ----------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always #5 clk = ~clk;
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        alvl <= rnd[3];
        if (snap) nsnap <= nsnap + 8'h01;
        if (clr) nclr <= nclr + 8'h01;
        if (sst) nsst <= nsst + 8'h01;
    end
    task chk_pin(input [7:0] g, input [7:0] x);
        tests_run++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t pin got %h exp %h", $time, g, x);
        end
    endtask
    task chk_reg(input [32:0] g, input [32:0] x);
        tests_run++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, g, x);
        end
    endtask
    // error reads expect no particular data, only the error flag
    always @(posedge clk) if (psel && pen && prdy && !pwr) begin
        e = exq.pop_front();
        chk_reg({perr, e[32] ? 32'h0 : prdata}, e);
    end
    task apb(input w, input [7:0] a, input [31:0] d);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        // ends once prdy is seen high; only the watchdog ends it if prdy never rises
        do @(posedge clk); while (prdy !== 1'b1);
        psel <= 0;
        pen <= 0;
        // one idle edge, so a following call never re-raises psel in this step
        @(posedge clk);
    endtask
    task rd(input [7:0] a, input [32:0] x);
        exq.push_back(x);
        apb(0, a, 32'h0);
    endtask
    task wdone;
        @(posedge done);
        repeat (3) @(posedge clk);
    endtask
    task setp(input v);
        pin <= v;
        repeat (8) @(posedge clk);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        stop_test;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk_pin(rate, `RATE_1024);
        rd(`ADDR_CTRL, 33'h0);
        rd(`ADDR_SLOW, 33'h0);
        rd(8'h40, {1'b1, 32'h0});
        $display("test reset done");
        wdone;
        s0 = nsnap;
        c0 = nclr;
        setp(1);
        chk_pin(rate, `RATE_1024);
        chk_pin(nsnap - s0, 1);
        chk_pin(nclr - c0, 1);
        rd(`ADDR_SLOW, 33'h18);
        wdone;
        chk_pin(rate, `RATE_8);
        $display("test rise done");
        apb(1, `ADDR_SLOW, 32'h31);
        s0 = nsnap;
        c0 = nclr;
        setp(0);
        chk_pin(nsnap - s0, 1);
        chk_pin(nclr - c0, 0);
        rd(`ADDR_SLOW, 33'h21);
        wdone;
        chk_pin(rate, `RATE_1024);
        apb(1, `ADDR_SLOW, 32'h23);
        s0 = nsnap;
        setp(1);
        chk_pin(nsnap - s0, 0);
        $display("test fall done");
        apb(1, `ADDR_CTRL, 32'h10);
        wdone;
        chk_pin({aoe, rate}, 8'h04);
        apb(1, `ADDR_CTRL, 32'h13);
        wdone;
        chk_pin({aoe, rate}, 8'h07);
        $display("test alert done");
        apb(1, `ADDR_CTRL, 32'h44);
        wdone;
        apb(1, `ADDR_SLOW, 32'h30);
        setp(0);
        pin <= 1;
        m = 0;
        do begin @(posedge clk); m++; end while (sst !== 1'b1 && m < 100);
        chk_pin(m >= 20 && m <= 26, 1);
        $display("test single done");
        apb(1, `ADDR_CTRL, 32'h08);
        wdone;
        setp(0);
        s0 = nsst;
        setp(1);
        repeat (40) @(posedge clk);
        chk_pin(nsst - s0, 0);
        $display("test sleep done");
        stop_test;
    end
endmodule
